// ==== src/addr_break_pkg.sv ====
package addr_break_pkg;

	// Register offsets; a 16-bit register occupies two byte addresses
	localparam logic [15:0] OFS_CONDITION  = 16'hf096;
	localparam logic [15:0] OFS_STATUS     = 16'hf097;
	localparam logic [15:0] OFS_ADDR_HIGH  = 16'hf098;
	localparam logic [15:0] OFS_ADDR_LOW   = 16'hf099;
	localparam logic [15:0] OFS_DATA_HIGH  = 16'hf09a;
	localparam logic [15:0] OFS_DATA_LOW   = 16'hf09b;
	localparam logic [15:0] OFS_IRQ_STATUS = 16'hf09c;
	localparam logic [15:0] OFS_IRQ_MASK   = 16'hf09d;

	// Field positions
	localparam int BIT_HIT_FLAG   = 7;
	localparam int BIT_IRQ_ENABLE = 6;
	localparam int BIT_RET_UNMASK = 7;
	localparam int BIT_CSEL_HI    = 6;
	localparam int BIT_CSEL_LO    = 5;
	localparam int BIT_ACMP_HI    = 4;
	localparam int BIT_ACMP_LO    = 2;
	localparam int BIT_DCMP_HI    = 1;
	localparam int BIT_DCMP_LO    = 0;

	// Reset values
	localparam logic [7:0]  RST_CONDITION = 8'h00;
	localparam logic [7:0]  RST_STATUS    = 8'h00;
	localparam logic [15:0] RST_ADDR      = 16'h0000;
	localparam logic [15:0] RST_DATA      = 16'h0000;
	localparam logic [1:0]  RST_EVT       = 2'h0;

	// Condition select codes
	localparam logic [1:0] CSEL_EXEC  = 2'h0;
	localparam logic [1:0] CSEL_READ  = 2'h1;
	localparam logic [1:0] CSEL_WRITE = 2'h2;

	// Address compare modes: number of low address bits ignored
	localparam logic [2:0] ACMP_FULL = 3'h0;

	localparam logic [1:0] DCMP_NONE = 2'h0;
	localparam logic [1:0] DCMP_BYTE = 2'h1;

	typedef struct packed {
		logic        exec;
		logic        rd;
		logic        wr;
		logic        return_from_exception;
		logic [15:0] addr;
		logic [15:0] data;
	} cpu_bus_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_s;

endpackage : addr_break_pkg

// ==== src/address_break_unit.sv ====
`timescale 1ns/100ps

module address_break_unit
(
	input  wire logic                     ref_clk,
	input  wire logic                     sys_rst,
	input  wire addr_break_pkg::reg_req_s req,
	output logic [7:0]                    rdata,
	input  wire addr_break_pkg::cpu_bus_s cpu,
	input  wire logic                     cpu_irq_masked,
	output logic                          break_irq,
	output logic                          irq
);

	logic [7:0]  cond_r;
	logic [7:0]  cond_nxt;
	logic        hit_r;
	logic        hit_nxt;
	logic        ien_r;
	logic        ien_nxt;
	logic        armed_r;
	logic        armed_nxt;
	logic [15:0] baddr_r;
	logic [15:0] baddr_nxt;
	logic [15:0] bdata_r;
	logic [15:0] bdata_nxt;
	logic [1:0]  evt_r;
	logic [1:0]  evt_nxt;
	logic [1:0]  emask_r;
	logic [1:0]  emask_nxt;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;
	logic        birq_r;
	logic        birq_nxt;
	logic        irq_r;
	logic        irq_nxt;
	logic        rte_win_r;
	logic        rte_win_nxt;

	logic [1:0]  csel;
	logic [2:0]  acmp;
	logic [1:0]  dcmp;
	logic [15:0] amask;
	logic        cycle_ok;
	logic        addr_ok;
	logic        data_ok;
	logic        match;
	logic        rd_status;

	always_comb
	begin
		csel = cond_r[addr_break_pkg::BIT_CSEL_HI:addr_break_pkg::BIT_CSEL_LO];
		acmp = cond_r[addr_break_pkg::BIT_ACMP_HI:addr_break_pkg::BIT_ACMP_LO];
		dcmp = cond_r[addr_break_pkg::BIT_DCMP_HI:addr_break_pkg::BIT_DCMP_LO];
		case (csel)
			addr_break_pkg::CSEL_EXEC:  cycle_ok = cpu.exec;
			addr_break_pkg::CSEL_READ:  cycle_ok = cpu.rd;
			addr_break_pkg::CSEL_WRITE: cycle_ok = cpu.wr;
			default:                    cycle_ok = cpu.rd | cpu.wr;
		endcase
		// Nonzero mode ignores that many low address bits
		amask = 16'hffff << acmp;
		if (acmp == addr_break_pkg::ACMP_FULL)
			amask = 16'hffff;
		addr_ok = ((cpu.addr ^ baddr_r) & amask) == 16'h0000;
		// Execution cycles carry no data, so no data test there
		if (dcmp == addr_break_pkg::DCMP_NONE || csel == addr_break_pkg::CSEL_EXEC)
			data_ok = 1'b1;
		else if (dcmp == addr_break_pkg::DCMP_BYTE)
			data_ok = cpu.data[15:8] == bdata_r[15:8];
		else
			data_ok = cpu.data[7:0] == bdata_r[7:0];
		match = cycle_ok & addr_ok & data_ok;
		rd_status = req.rd && req.addr == addr_break_pkg::OFS_STATUS;
	end

	always_comb
	begin
		cond_nxt    = cond_r;
		hit_nxt     = hit_r;
		ien_nxt     = ien_r;
		armed_nxt   = armed_r;
		baddr_nxt   = baddr_r;
		bdata_nxt   = bdata_r;
		emask_nxt   = emask_r;
		evt_nxt     = evt_r;
		rdata_nxt   = 8'h00;
		rte_win_nxt = cpu.return_from_exception;
		if (rd_status && hit_r)
			armed_nxt = 1'b1;
		if (req.wr)
		begin
			case (req.addr)
				addr_break_pkg::OFS_CONDITION: cond_nxt = req.wdata;
				addr_break_pkg::OFS_STATUS:
				begin
					ien_nxt = req.wdata[addr_break_pkg::BIT_IRQ_ENABLE];
					if (!req.wdata[addr_break_pkg::BIT_HIT_FLAG] && armed_r)
					begin
						hit_nxt   = 1'b0;
						armed_nxt = 1'b0;
					end
				end
				addr_break_pkg::OFS_ADDR_HIGH: baddr_nxt[15:8] = req.wdata;
				addr_break_pkg::OFS_ADDR_LOW:  baddr_nxt[7:0]  = req.wdata;
				addr_break_pkg::OFS_DATA_HIGH: bdata_nxt[15:8] = req.wdata;
				addr_break_pkg::OFS_DATA_LOW:  bdata_nxt[7:0]  = req.wdata;
				addr_break_pkg::OFS_IRQ_MASK:  emask_nxt = req.wdata[1:0];
				default: ;
			endcase
		end
		if (req.rd)
		begin
			case (req.addr)
				addr_break_pkg::OFS_CONDITION: rdata_nxt = cond_r;
				addr_break_pkg::OFS_STATUS:
					rdata_nxt = {hit_r, ien_r, 6'h00};
				addr_break_pkg::OFS_ADDR_HIGH: rdata_nxt = baddr_r[15:8];
				addr_break_pkg::OFS_ADDR_LOW:  rdata_nxt = baddr_r[7:0];
				addr_break_pkg::OFS_DATA_HIGH: rdata_nxt = bdata_r[15:8];
				addr_break_pkg::OFS_DATA_LOW:  rdata_nxt = bdata_r[7:0];
				addr_break_pkg::OFS_IRQ_STATUS:
				begin
					rdata_nxt = {6'h00, evt_r};
					evt_nxt   = 2'h0;
				end
				addr_break_pkg::OFS_IRQ_MASK:  rdata_nxt = {6'h00, emask_r};
				default:                       rdata_nxt = 8'h00;
			endcase
		end
		// Hardware set placed last so it wins over any clear
		if (match)
		begin
			hit_nxt    = 1'b1;
			evt_nxt[0] = 1'b1;
		end
		if (birq_nxt && !birq_r)
			evt_nxt[1] = 1'b1;
		irq_nxt = |(evt_nxt & emask_nxt);
	end

	// Request follows flag and enable; the return window can lift the core mask
	always_comb
	begin
		birq_nxt = hit_nxt & ien_nxt;
		if (cpu_irq_masked && !(rte_win_r && cond_r[addr_break_pkg::BIT_RET_UNMASK]))
			birq_nxt = 1'b0;
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cond_r    <= addr_break_pkg::RST_CONDITION;
			hit_r     <= addr_break_pkg::RST_STATUS[addr_break_pkg::BIT_HIT_FLAG];
			ien_r     <= addr_break_pkg::RST_STATUS[addr_break_pkg::BIT_IRQ_ENABLE];
			armed_r   <= 1'b0;
			baddr_r   <= addr_break_pkg::RST_ADDR;
			bdata_r   <= addr_break_pkg::RST_DATA;
			evt_r     <= addr_break_pkg::RST_EVT;
			emask_r   <= addr_break_pkg::RST_EVT;
			rdata_r   <= 8'h00;
			birq_r    <= 1'b0;
			irq_r     <= 1'b0;
			rte_win_r <= 1'b0;
		end
		else
		begin
			cond_r    <= cond_nxt;
			hit_r     <= hit_nxt;
			ien_r     <= ien_nxt;
			armed_r   <= armed_nxt;
			baddr_r   <= baddr_nxt;
			bdata_r   <= bdata_nxt;
			evt_r     <= evt_nxt;
			emask_r   <= emask_nxt;
			rdata_r   <= rdata_nxt;
			birq_r    <= birq_nxt;
			irq_r     <= irq_nxt;
			rte_win_r <= rte_win_nxt;
		end
	end

	assign rdata     = rdata_r;
	assign break_irq = birq_r;
	assign irq       = irq_r;

endmodule : address_break_unit

// ==== bench/break_asserts.sv ====
`timescale 1ns/100ps
module break_asserts
(
	input wire logic                     ref_clk,
	input wire logic                     sys_rst,
	input wire addr_break_pkg::reg_req_s req,
	input wire logic [7:0]               rdata,
	input wire addr_break_pkg::cpu_bus_s cpu,
	input wire logic                     cpu_irq_masked,
	input wire logic                     break_irq,
	input wire logic                     irq
);
	logic [15:0] ba_r;
	logic [7:0]  cond_r;
	logic        en_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Shadows of what software wrote, so the request can be predicted from the ports alone
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
			{ba_r, cond_r, en_r} <= '0;
		else if (req.wr)
			case (req.addr)
				16'hf096: cond_r <= req.wdata;
				16'hf097: en_r <= req.wdata[6];
				16'hf098: ba_r[15:8] <= req.wdata;
				16'hf099: ba_r[7:0] <= req.wdata;
				default: ;
			endcase
	match_irq_a: assert property (cpu.exec && cpu.addr == ba_r && cond_r[6:0] == 7'h00
		&& en_r && !cpu_irq_masked && !req.wr |=> break_irq) else $error("missed break");
	irq_gate_a: assert property (!en_r && $past(!en_r) |-> !break_irq)
		else $error("request while disabled");
	masked_block_a: assert property (cpu_irq_masked && !cpu.return_from_exception ##1 cpu_irq_masked
		&& !cpu.return_from_exception |=> !break_irq) else $error("request while masked");
	rte_pass_a: assert property (break_irq && cond_r[7] && cpu.return_from_exception && !req.wr
		##1 cpu_irq_masked && !req.wr |=> break_irq) else $error("return unmask ignored");
	irq_hold_a: assert property (break_irq && !req.wr && !cpu_irq_masked |=> break_irq)
		else $error("request dropped");
	addr_read_a: assert property (req.rd && req.addr == 16'hf098 |=> rdata == ba_r[15:8])
		else $error("bad address readback");
	status_read_a: assert property (req.rd && req.addr == 16'hf097
		|=> rdata[6:0] == {$past(en_r), 6'h00}) else $error("bad status readback");
	no_match_a: assert property (!break_irq && $stable(en_r) && !cpu_irq_masked
		&& $past(!cpu_irq_masked) && cond_r == 8'h00 && !req.wr && ((cpu.exec
		&& cpu.addr == (ba_r ^ 16'h0001)) || (cpu.rd && !cpu.exec && cpu.addr == ba_r))
		|=> !break_irq) else $error("false break");
endmodule : break_asserts
bind address_break_unit break_asserts break_asserts_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.req(req), .rdata(rdata), .cpu(cpu), .cpu_irq_masked(cpu_irq_masked),
	.break_irq(break_irq), .irq(irq));

// ==== bench/core_model.sv ====
`timescale 1ns/100ps
module core_model
(
	input  wire logic                ref_clk,
	output addr_break_pkg::cpu_bus_s cpu,
	output logic                     cpu_irq_masked
);
	initial
	begin
		cpu = '0;
		cpu_irq_masked = 1'b0;
	end
	// Kind is {exec, rd, wr, rte}; data flips each cycle so a stale value never looks valid
	task automatic cycle(input logic [3:0] kind, input logic [15:0] a, input logic msk);
		@(posedge ref_clk);
		cpu <= {kind, a, ~cpu.data};
		cpu_irq_masked <= msk;
	endtask : cycle
endmodule : core_model

// ==== bench/address_break_unit_tb.sv ====
`timescale 1ns/100ps
module address_break_unit_tb;
	logic                     ref_clk = 1'b0;
	logic                     sys_rst = 1'b1;
	addr_break_pkg::reg_req_s req = '0;
	addr_break_pkg::cpu_bus_s cpu;
	logic                     cpu_irq_masked, break_irq, irq;
	logic [7:0]               rdata;
	int                       bad_count = 0;
	int                       compares = 0;
	int                       cycles = 0;
	always #4 ref_clk = ~ref_clk;
	address_break_unit address_break_unit_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req),
		.rdata(rdata), .cpu(cpu), .cpu_irq_masked(cpu_irq_masked), .break_irq(break_irq), .irq(irq));
	core_model core_model_inst (.ref_clk(ref_clk), .cpu(cpu), .cpu_irq_masked(cpu_irq_masked));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{a, d, w, !w};
		@(posedge ref_clk);
		req <= '0;
		#1;
	endtask : acc
	task automatic cyc(input logic [3:0] k, input logic [15:0] a, input logic m);
		core_model_inst.cycle(k, a, m);
		core_model_inst.cycle(4'h0, a, m);
		#1;
	endtask : cyc
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			bad_count++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		acc(1'b0, 16'hf097, 8'h00);
		check("status reset", rdata, 8'h00);
		acc(1'b0, 16'hf0a0, 8'h00);
		check("unmapped", rdata, 8'h00);
		acc(1'b1, 16'hf098, 8'h12);
		acc(1'b1, 16'hf099, 8'h34);
		acc(1'b0, 16'hf099, 8'h00);
		check("addr low", rdata, 8'h34);
		acc(1'b1, 16'hf097, 8'h40);
		cyc(4'h8, 16'h1234, 1'b0);
		check("break_irq", break_irq, 8'h01);
		acc(1'b1, 16'hf097, 8'h40);
		acc(1'b0, 16'hf097, 8'h00);
		check("unarmed clear", rdata, 8'hc0);
		acc(1'b1, 16'hf097, 8'h40);
		check("cleared", break_irq, 8'h00);
		cyc(4'h8, 16'h1235, 1'b0);
		cyc(4'h4, 16'h1234, 1'b0);
		acc(1'b0, 16'hf097, 8'h00);
		check("no match", rdata, 8'h40);
		acc(1'b1, 16'hf096, 8'h80);
		cyc(4'h8, 16'h1234, 1'b1);
		cyc(4'h0, 16'h1234, 1'b1);
		check("masked", break_irq, 8'h00);
		cyc(4'h0, 16'h1234, 1'b0);
		check("unmasked", break_irq, 8'h01);
		// Core masks right after the return; the window keeps the request up one cycle
		core_model_inst.cycle(4'h1, 16'h1234, 1'b0);
		core_model_inst.cycle(4'h0, 16'h1234, 1'b1);
		core_model_inst.cycle(4'h0, 16'h1234, 1'b1);
		#1;
		check("return window", break_irq, 8'h01);
		core_model_inst.cycle(4'h0, 16'h1234, 1'b1);
		#1;
		check("masked again", break_irq, 8'h00);
		acc(1'b0, 16'hf097, 8'h00);
		acc(1'b1, 16'hf097, 8'h40);
		acc(1'b1, 16'hf096, 8'h00);
		check("rdata idle", rdata, 8'h00);
		acc(1'b0, 16'hf09c, 8'h00);
		acc(1'b1, 16'hf09d, 8'h00);
		cyc(4'h8, 16'h1234, 1'b0);
		check("irq masked", irq, 8'h00);
		acc(1'b1, 16'hf09d, 8'h01);
		check("irq", irq, 8'h01);
		acc(1'b0, 16'hf09c, 8'h00);
		check("events", rdata, 8'h03);
		check("irq clear", irq, 8'h00);
		acc(1'b0, 16'hf09c, 8'h00);
		check("events clear", rdata, 8'h00);
		print_verdict();
	end
endmodule : address_break_unit_tb
